/* src/payload_tail.v */
// Pixel shader payload tail assembly and shader invocation statistics.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "payload_tail_defines.vh"

// How it works
// [RL1] Return-buffer data starts at configured dispatch register; code starts it at the header end when the header is longer.
// [RL2] That start ignores optional header length; code moves it to the header end for a longer header.
// [RL3] Gap before start is padding, written zero.
// [RL4] Optional constant data, 8-dword units, configured.
// [RL5] Setup data appended last, 8-dword units.
// [RL6] Setup read from object's strips-fans entry handle.
// [RL7] Setup content copied through, never reinterpreted.
// [RL8] Attribute zero fills dwords 0 to 3.
// [RL9] Attribute one fills dwords 4 to 7.
// [RL10] Further attributes follow in later registers.
// [RL11] Stats enabled: count each unmasked dispatched pixel.
// [RL12] Early-depth discarded pixels still counted.
// [RL13] Null shader pixels counted unless stats cleared.
// [RL14] Stats off also freezes depth-pass counter.
module payload_tail (
  // System clock and reset.
  input wire CLK_SYS,
  input wire SYS_RST,
  // APB slave port.
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Dispatch request: header length in registers, handle and pixel mask.
  input wire DISP_VALID,
  input wire [6:0] DISP_HDR_REGS,
  input wire [15:0] DISP_SETUP_HANDLE,
  input wire [15:0] DISP_CONST_HANDLE,
  input wire [7:0] DISP_PIXEL_MASK,
  input wire [7:0] DISP_DEPTH_PASS,
  output reg DISP_READY,
  // Return buffer read port: one dword per cycle, data one cycle later.
  output reg RB_RD_EN,
  output reg [15:0] RB_HANDLE,
  output reg [9:0] RB_DW_ADDR,
  input wire [31:0] RB_RD_DATA,
  // Payload write stream toward the thread: register index, dword and data.
  output reg PL_VALID,
  output reg [6:0] PL_REG,
  output reg [2:0] PL_DW,
  output reg [31:0] PL_DATA,
  output reg PL_LAST
);

  // States of the payload tail sequencer, one-hot.
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_PAD = 4'b0010;
  localparam [3:0] S_CONST = 4'b0100;
  localparam [3:0] S_SETUP = 4'b1000;

  // Software state.
  reg [31:0] ctrl_reg; // Statistics and early depth enables.
  reg [6:0] dispatch_start_reg; // Register index where return-buffer data begins.
  reg [`LEN_W-1:0] const_len_reg; // Constant data length in registers.
  reg [`LEN_W-1:0] const_ofs_reg; // Constant read offset in registers.
  reg [`LEN_W-1:0] setup_len_reg; // Setup data length in registers.
  reg [`LEN_W-1:0] setup_ofs_reg; // Setup read offset in registers.
  reg [63:0] inv_cnt_reg; // Shader invocation counter.
  reg [63:0] depth_cnt_reg; // Depth-pass counter.
  // Sequencer state.
  reg [3:0] state_reg;
  reg [6:0] reg_idx_reg; // Payload register being written.
  reg [2:0] dw_reg; // Dword within that register.
  reg [`LEN_W-1:0] left_reg; // Registers left in the current section.
  reg [`LEN_W-1:0] src_reg; // Source register within the entry.
  reg [15:0] setup_handle_reg; // Captured handle of the object.
  reg [15:0] const_handle_reg; // Captured handle of the constant entry.
  // Read pipeline: fetched dword lands one cycle after the request.
  reg rd_pend_reg;
  reg [6:0] rd_reg_idx_reg;
  reg [2:0] rd_dw_reg;
  reg rd_last_reg;
  // Second stage: the buffer answers at the edge after the request, so the
  // dword is sampled one edge later still. Sampling it together with the
  // request would copy whatever the buffer showed before, never the answer.
  reg rd_land_reg; // Fetched dword stands on the read data port now.
  reg [6:0] land_reg_idx_reg; // Payload register of the landing dword.
  reg [2:0] land_dw_reg; // Dword index of the landing dword.
  reg land_last_reg; // Landing dword closes the payload.

  // Per-pixel count of unmasked and depth-passing pixels.
  // An adder chain keeps the per-lane logic in one loop; with eight lanes
  // the chain stays short enough to settle within one clock.
  wire [3:0] pix_count;
  wire [3:0] pass_count;
  wire [3:0] pix_part [0:8];
  wire [3:0] pass_part [0:8];
  assign pix_part[0] = 4'h0;
  assign pass_part[0] = 4'h0;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pix
      // Each unmasked lane adds one, including early-discarded ones.
      assign pix_part[g+1] = pix_part[g] + {3'h0, DISP_PIXEL_MASK[g]}; // see [RL12]
      assign pass_part[g+1] = pass_part[g] + {3'h0, DISP_PIXEL_MASK[g] & DISP_DEPTH_PASS[g]};
    end
  endgenerate
  assign pix_count = pix_part[8];
  assign pass_count = pass_part[8];

  // Bus qualifiers, the dispatch handshake and section end detection.
  // A section ends on the last dword of its last register.
  wire apb_wr = PSEL & PENABLE & PWRITE;
  wire apb_rd = PSEL & PENABLE & ~PWRITE;
  wire stats_en = ctrl_reg[`CTRL_STATS_EN];
  wire take = DISP_VALID & DISP_READY;
  wire dw_end = (dw_reg == `DW_LAST);
  wire sec_end = dw_end & (left_reg == {{(`LEN_W-1){1'b0}}, 1'b1});

  // Address decode: known offsets answer, others report a slave error.
  // The full address is decoded so that no alias answers by accident.
  reg addr_ok;
  always @* begin
    case (PADDR)
      `OFS_CTRL, `OFS_DISPATCH, `OFS_CONST, `OFS_SETUP, `OFS_INV_LO, `OFS_INV_HI,
      `OFS_DEPTH_LO, `OFS_DEPTH_HI, `OFS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // APB slave: one wait state, then PREADY for a single cycle.
  // A write lands at the first access-phase edge; answering one cycle on
  // keeps every bus output registered, at the cost of one extra bus cycle.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= `DW_ZERO;
      ctrl_reg <= `CTRL_RESET;
      dispatch_start_reg <= `REG_ZERO;
      const_len_reg <= `FIELD_ZERO;
      const_ofs_reg <= `FIELD_ZERO;
      setup_len_reg <= `FIELD_ZERO;
      setup_ofs_reg <= `FIELD_ZERO;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
      PRDATA <= `DW_ZERO;
      // Clear bits are pulses; they never stick in the register.
      ctrl_reg[`CTRL_CLR_INV] <= 1'b0;
      ctrl_reg[`CTRL_CLR_DEPTH] <= 1'b0;
      if (apb_wr & ~PREADY) begin
        case (PADDR)
          // Only the four control bits exist; the rest of the word is dropped.
          `OFS_CTRL: ctrl_reg <= {28'h0, PWDATA[`CTRL_CLR_DEPTH:`CTRL_STATS_EN]}; // see [RL13]
          // The start index spans the whole payload register index.
          `OFS_DISPATCH: dispatch_start_reg <= PWDATA[`START_MSB:`START_LSB]; // see [RL1]
          `OFS_CONST: begin
            const_len_reg <= PWDATA[`LEN_W-1:0]; // see [RL4]
            const_ofs_reg <= PWDATA[`LEN_OFS_LSB+`LEN_W-1:`LEN_OFS_LSB];
          end
          `OFS_SETUP: begin
            setup_len_reg <= PWDATA[`LEN_W-1:0]; // see [RL5]
            setup_ofs_reg <= PWDATA[`LEN_OFS_LSB+`LEN_W-1:`LEN_OFS_LSB];
          end
          default: begin
            // Counters and status are read-only.
          end
        endcase
      end
      if (apb_rd & ~PREADY) begin
        case (PADDR)
          // Clear bits are pulses and always read back as zero.
          `OFS_CTRL: PRDATA <= {30'h0, ctrl_reg[`CTRL_EARLY_DEPTH:`CTRL_STATS_EN]};
          `OFS_DISPATCH: PRDATA <= {25'h0, dispatch_start_reg};
          `OFS_CONST: PRDATA <= {18'h0, const_ofs_reg, 2'h0, const_len_reg};
          `OFS_SETUP: PRDATA <= {18'h0, setup_ofs_reg, 2'h0, setup_len_reg};
          `OFS_INV_LO: PRDATA <= inv_cnt_reg[31:0];
          `OFS_INV_HI: PRDATA <= inv_cnt_reg[63:32];
          `OFS_DEPTH_LO: PRDATA <= depth_cnt_reg[31:0];
          `OFS_DEPTH_HI: PRDATA <= depth_cnt_reg[63:32];
          `OFS_STATUS: PRDATA <= {28'h0, state_reg};
          default: PRDATA <= `DW_ZERO;
        endcase
      end
    end
  end

  // Statistics: both counters only count up while the statistics enable is set.
  // A clear pulse in the same cycle as a dispatch restarts from that dispatch.
  // Both counters share one enable, so clearing it for a null shader also
  // stops depth-pass counting: the two cannot both stay exact then.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      inv_cnt_reg <= `CNT_ZERO;
      depth_cnt_reg <= `CNT_ZERO;
    end else begin
      if (ctrl_reg[`CTRL_CLR_INV])
        inv_cnt_reg <= (take & stats_en) ? {60'h0, pix_count} : `CNT_ZERO;
      else if (take & stats_en)
        inv_cnt_reg <= inv_cnt_reg + {60'h0, pix_count}; // see [RL11] see [RL13]
      if (ctrl_reg[`CTRL_CLR_DEPTH])
        depth_cnt_reg <= (take & stats_en) ? {60'h0, pass_count} : `CNT_ZERO;
      else if (take & stats_en)
        depth_cnt_reg <= depth_cnt_reg + {60'h0, pass_count}; // see [RL14]
    end
  end

  // Sequencer: pad up to the fixed start, then constant, then setup data.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= S_IDLE;
      DISP_READY <= 1'b0;
      reg_idx_reg <= `REG_ZERO;
      dw_reg <= `DW_IDX_ZERO;
      left_reg <= `FIELD_ZERO;
      src_reg <= `FIELD_ZERO;
      setup_handle_reg <= `HANDLE_ZERO;
      const_handle_reg <= `HANDLE_ZERO;
      RB_RD_EN <= 1'b0;
      RB_HANDLE <= `HANDLE_ZERO;
      RB_DW_ADDR <= `RB_ADDR_ZERO;
      rd_pend_reg <= 1'b0;
      rd_reg_idx_reg <= `REG_ZERO;
      rd_dw_reg <= `DW_IDX_ZERO;
      rd_last_reg <= 1'b0;
      // Second read stage.
      rd_land_reg <= 1'b0;
      land_reg_idx_reg <= `REG_ZERO;
      land_dw_reg <= `DW_IDX_ZERO;
      land_last_reg <= 1'b0;
      PL_VALID <= 1'b0;
      PL_REG <= `REG_ZERO;
      PL_DW <= `DW_IDX_ZERO;
      PL_DATA <= `DW_ZERO;
      PL_LAST <= 1'b0;
    end else begin
      RB_RD_EN <= 1'b0;
      PL_VALID <= 1'b0;
      PL_LAST <= 1'b0;
      // First read stage: the request stands on the buffer port this cycle.
      rd_pend_reg <= 1'b0;
      rd_land_reg <= rd_pend_reg;
      land_reg_idx_reg <= rd_reg_idx_reg;
      land_dw_reg <= rd_dw_reg;
      land_last_reg <= rd_last_reg;
      // Second read stage: the answer stands now and is copied through
      // untouched, in entry order; its layout belongs to the setup program.
      if (rd_land_reg) begin
        PL_VALID <= 1'b1;
        PL_REG <= land_reg_idx_reg;
        PL_DW <= land_dw_reg;
        PL_DATA <= RB_RD_DATA; // see [RL7] see [RL8] see [RL9]
        PL_LAST <= land_last_reg;
      end
      case (state_reg)
        S_IDLE: begin
          // Ready stays low until both read stages have drained, so a new
          // object's padding can never share a cycle with an old dword.
          DISP_READY <= ~DISP_READY & ~rd_pend_reg & ~rd_land_reg;
          if (take) begin
            DISP_READY <= 1'b0;
            // Handles are held so the request lines may change once taken.
            setup_handle_reg <= DISP_SETUP_HANDLE; // see [RL6]
            const_handle_reg <= DISP_CONST_HANDLE;
            reg_idx_reg <= DISP_HDR_REGS;
            dw_reg <= 3'h0;
            left_reg <= const_len_reg;
            src_reg <= const_ofs_reg;
            // Start moves to the header end only when the header is longer, which skips padding.
            if (DISP_HDR_REGS < dispatch_start_reg)
              state_reg <= S_PAD; // see [RL2]
            else
              state_reg <= S_CONST;
            if (DISP_HDR_REGS > dispatch_start_reg)
              reg_idx_reg <= DISP_HDR_REGS;
            else if (DISP_HDR_REGS == dispatch_start_reg)
              reg_idx_reg <= dispatch_start_reg; // see [RL1]
          end
        end
        S_PAD: begin
          // Padding content is undefined; zeros keep it deterministic.
          // One padding dword per cycle, no buffer read is needed for it.
          PL_VALID <= 1'b1;
          PL_REG <= reg_idx_reg;
          PL_DW <= dw_reg;
          PL_DATA <= `DW_ZERO; // see [RL3]
          dw_reg <= dw_reg + 3'h1;
          if (dw_end) begin
            reg_idx_reg <= reg_idx_reg + 7'h01;
            if (reg_idx_reg + 7'h01 == dispatch_start_reg)
              state_reg <= S_CONST;
          end
        end
        S_CONST: begin
          if (left_reg == `FIELD_ZERO) begin
            // Constant data is optional; go straight to setup.
            state_reg <= S_SETUP;
            left_reg <= setup_len_reg;
            src_reg <= setup_ofs_reg;
          end else begin
            RB_RD_EN <= 1'b1;
            RB_HANDLE <= const_handle_reg;
            RB_DW_ADDR <= {1'b0, src_reg, dw_reg}; // see [RL4]
            rd_pend_reg <= 1'b1;
            rd_reg_idx_reg <= reg_idx_reg;
            rd_dw_reg <= dw_reg;
            // Constant data ends the payload only when no setup data follows.
            rd_last_reg <= sec_end & (setup_len_reg == `FIELD_ZERO);
            dw_reg <= dw_reg + 3'h1;
            if (dw_end) begin
              reg_idx_reg <= reg_idx_reg + 7'h01;
              src_reg <= src_reg + 6'h01;
              left_reg <= left_reg - 6'h01;
            end
          end
        end
        S_SETUP: begin
          if (left_reg == `FIELD_ZERO) begin
            // All setup reads issued; the read stages drain by themselves.
            state_reg <= S_IDLE;
          end else begin
            // Eight dwords per register: attribute pairs, then later registers.
            RB_RD_EN <= 1'b1;
            RB_HANDLE <= setup_handle_reg; // see [RL6]
            RB_DW_ADDR <= {1'b0, src_reg, dw_reg}; // see [RL5] see [RL10]
            rd_pend_reg <= 1'b1;
            rd_reg_idx_reg <= reg_idx_reg;
            rd_dw_reg <= dw_reg;
            rd_last_reg <= sec_end;
            dw_reg <= dw_reg + 3'h1;
            if (dw_end) begin
              reg_idx_reg <= reg_idx_reg + 7'h01;
              src_reg <= src_reg + 6'h01;
              left_reg <= left_reg - 6'h01;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // payload_tail
`default_nettype wire

/* src/payload_tail_defines.vh */
// Register offsets, field positions and reset values for the payload tail block.
`ifndef PAYLOAD_TAIL_DEFINES_VH
`define PAYLOAD_TAIL_DEFINES_VH
// Register byte offsets on the APB port.
`define OFS_CTRL 12'h000
`define OFS_DISPATCH 12'h004
`define OFS_CONST 12'h008
`define OFS_SETUP 12'h00c
`define OFS_INV_LO 12'h010
`define OFS_INV_HI 12'h014
`define OFS_DEPTH_LO 12'h018
`define OFS_DEPTH_HI 12'h01c
`define OFS_STATUS 12'h020
// Control register fields.
`define CTRL_STATS_EN 0
`define CTRL_EARLY_DEPTH 1
`define CTRL_CLR_INV 2
`define CTRL_CLR_DEPTH 3
// Length and offset fields are 6 bits, counted in 8-dword units.
`define LEN_W 6
`define LEN_OFS_LSB 8
`define FIELD_ZERO 6'h00
// Dwords in one payload register.
`define DW_PER_REG 4'h8
`define DW_LAST 3'h7
// Reset values.
`define CTRL_RESET 32'h0000_0000
`define CNT_ZERO 64'h0000_0000_0000_0000
`define CNT_ONE 64'h0000_0000_0000_0001
`define DW_ZERO 32'h0000_0000
`define REG_ZERO 7'h00
`define DW_IDX_ZERO 3'h0
`define HANDLE_ZERO 16'h0000
`define RB_ADDR_ZERO 10'h000
// Dispatch start field: the whole payload register index.
`define START_MSB 6
`define START_LSB 0
`endif

/* verif/payload_tail_sva.sv */
// Port checker for the payload tail block.
`timescale 1ns/1ps
`default_nettype none
module payload_tail_sva (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Register bus.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA,
  // Dispatch and payload stream.
  input wire logic DISP_VALID,
  input wire logic DISP_READY,
  input wire logic RB_RD_EN,
  input wire logic PL_VALID,
  input wire logic [6:0] PL_REG,
  input wire logic [2:0] PL_DW,
  input wire logic PL_LAST
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  a_bus_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("bus access not answered");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_read_lag: assert property (RB_RD_EN |-> ##2 PL_VALID)
    else $error("fetched dword not forwarded");
  a_dw_order: assert property (PL_VALID && PL_DW != 3'h7 |=>
    PL_VALID && PL_DW == $past(PL_DW) + 3'h1 && PL_REG == $past(PL_REG)) else $error("dword order broken");
  a_reg_step: assert property (PL_VALID && PL_DW == 3'h7 && !PL_LAST |=>
    !PL_VALID || PL_REG == $past(PL_REG) + 7'h1) else $error("register step broken");
  a_last_dw: assert property (PL_LAST |-> PL_VALID && PL_DW == 3'h7)
    else $error("last flag misplaced");
  a_busy_refuse: assert property (DISP_VALID && DISP_READY |=> !DISP_READY [*2])
    else $error("dispatch taken while busy");
endmodule // payload_tail_sva
bind payload_tail payload_tail_sva u_sva (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .DISP_VALID(DISP_VALID),
  .DISP_READY(DISP_READY), .RB_RD_EN(RB_RD_EN), .PL_VALID(PL_VALID), .PL_REG(PL_REG),
  .PL_DW(PL_DW), .PL_LAST(PL_LAST));
`default_nettype wire

/* verif/payload_tail_tb.sv */
// Self-checking bench for the payload tail block.
`timescale 1ns/1ps
`default_nettype none
`include "payload_tail_defines.vh"
module payload_tail_tb;
  // Design signals.
  logic CLK_SYS, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic DISP_VALID, DISP_READY, RB_RD_EN, PL_VALID, PL_LAST;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, RB_RD_DATA, PL_DATA;
  logic [6:0] DISP_HDR_REGS, PL_REG;
  logic [15:0] DISP_SETUP_HANDLE, DISP_CONST_HANDLE, RB_HANDLE;
  logic [7:0] DISP_PIXEL_MASK, DISP_DEPTH_PASS;
  logic [9:0] RB_DW_ADDR;
  logic [2:0] PL_DW;
  // Counters, expected payload stream and last bus answer.
  int n_errors = 0, compares = 0, cycles = 0;
  logic [42:0] exp_q[$];
  logic [31:0] rd;
  logic err;
  payload_tail uut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DISP_VALID(DISP_VALID), .DISP_HDR_REGS(DISP_HDR_REGS), .DISP_SETUP_HANDLE(DISP_SETUP_HANDLE),
    .DISP_CONST_HANDLE(DISP_CONST_HANDLE), .DISP_PIXEL_MASK(DISP_PIXEL_MASK), .DISP_DEPTH_PASS(DISP_DEPTH_PASS),
    .DISP_READY(DISP_READY), .RB_RD_EN(RB_RD_EN), .RB_HANDLE(RB_HANDLE), .RB_DW_ADDR(RB_DW_ADDR),
    .RB_RD_DATA(RB_RD_DATA), .PL_VALID(PL_VALID), .PL_REG(PL_REG), .PL_DW(PL_DW), .PL_DATA(PL_DATA),
    .PL_LAST(PL_LAST));
  rb_model u_rb (.clk(CLK_SYS), .rd_en(RB_RD_EN), .handle(RB_HANDLE), .dw_addr(RB_DW_ADDR), .rd_data(RB_RD_DATA));
  // Free-running 200 MHz clock.
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  // Compare and count; case inequality so unknowns never match.
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Summary and verdict; the only end of the run.
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the tests need.
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  // One APB transfer; an idle edge first keeps psel from being set twice in one step.
  // The access phase lasts as long as the slave needs; only the hang guard ends a stuck wait.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (!PREADY);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Queue one expected payload dword.
  function automatic void put(int r, int j, logic [31:0] d);
    exp_q.push_back({7'(r), 3'(j), d, 1'b0});
  endfunction
  // Configure layout, dispatch one object and wait for its payload.
  task automatic disp(input int hdr, st, cl, co, sl, so, input logic [7:0] m, dp);
    int base, k;
    apb(1'b1, `OFS_DISPATCH, 32'(st));
    apb(1'b1, `OFS_CONST, 32'(co * 256 + cl));
    apb(1'b1, `OFS_SETUP, 32'(so * 256 + sl));
    base = hdr > st ? hdr : st;
    for (k = 8 * hdr; k < 8 * st; k++) put(k / 8, k % 8, 32'h0);
    for (k = 0; k < 8 * cl; k++) put(base + k / 8, k % 8, {16'h00c1, 7'h00, 6'(co + k / 8), 3'(k % 8)});
    base = base + cl;
    for (k = 0; k < 8 * sl; k++) put(base + k / 8, k % 8, {16'h05e7, 7'h00, 6'(so + k / 8), 3'(k % 8)});
    if (cl + sl > 0) exp_q[$][0] = 1'b1;
    DISP_HDR_REGS <= 7'(hdr);
    DISP_PIXEL_MASK <= m;
    DISP_DEPTH_PASS <= dp;
    DISP_VALID <= 1'b1;
    do @(posedge CLK_SYS); while (!DISP_READY);
    DISP_VALID <= 1'b0;
    k = 0;
    while (exp_q.size() > 0 && k < 500) begin
      @(posedge CLK_SYS);
      k++;
    end
    chk("dwords missing", 64'h0, 64'(exp_q.size()));
    repeat (3) @(posedge CLK_SYS);
  endtask
  // Every payload dword against the queue, in order.
  always @(posedge CLK_SYS) begin
    if (PL_VALID) begin
      if (exp_q.size() == 0) chk("extra dword", 64'h0, 64'h1);
      else chk("payload", 64'(exp_q.pop_front()), {PL_REG, PL_DW, PL_DATA, PL_LAST});
    end
  end
  // Main sequence.
  initial begin
    SYS_RST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, DISP_VALID, DISP_HDR_REGS, DISP_PIXEL_MASK, DISP_DEPTH_PASS} = '0;
    DISP_CONST_HANDLE = 16'h00c1;
    DISP_SETUP_HANDLE = 16'h05e7;
    repeat (5) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl reset", 64'(`CTRL_RESET), 64'(rd));
    apb(1'b0, 12'h024, 32'h0);
    chk("unmapped error", 64'h1, 64'(err));
    chk("unmapped data", 64'h0, 64'(rd));
    apb(1'b1, `OFS_CTRL, 32'h1);
    disp(2, 4, 1, 2, 2, 1, 8'hb5, 8'h05);
    apb(1'b0, `OFS_INV_LO, 32'h0);
    chk("invocations", 64'h5, 64'(rd));
    apb(1'b0, `OFS_DEPTH_LO, 32'h0);
    chk("depth passes", 64'h2, 64'(rd));
    apb(1'b1, `OFS_CTRL, 32'h3);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl readback", 64'h3, 64'(rd));
    disp(6, 4, 0, 0, 1, 3, 8'hff, 8'h00);
    apb(1'b0, `OFS_INV_LO, 32'h0);
    chk("invocations", 64'hd, 64'(rd));
    apb(1'b1, `OFS_CTRL, 32'h0);
    disp(0, 0, 2, 0, 0, 0, 8'hff, 8'hff);
    apb(1'b0, `OFS_INV_LO, 32'h0);
    chk("invocations", 64'hd, 64'(rd));
    apb(1'b0, `OFS_DEPTH_LO, 32'h0);
    chk("depth passes", 64'h2, 64'(rd));
    apb(1'b1, `OFS_CTRL, 32'hd);
    apb(1'b0, `OFS_INV_LO, 32'h0);
    chk("cleared count", 64'h0, 64'(rd));
    apb(1'b0, `OFS_INV_HI, 32'h0);
    chk("count high", 64'h0, 64'(rd));
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status idle", 64'h1, 64'(rd));
    conclude();
  end
endmodule // payload_tail_tb
`default_nettype wire

/* verif/rb_model.sv */
// Return buffer model answering one dword the cycle after each read.
`timescale 1ns/1ps
`default_nettype none
module rb_model (
  // Clock.
  input wire logic clk,
  // Read request from the block.
  input wire logic rd_en,
  input wire logic [15:0] handle,
  input wire logic [9:0] dw_addr,
  // Read data toward the block.
  output var logic [31:0] rd_data = 32'h5a5a_5a5a
);
  // Data carries handle and address, so a wrong fetch shows in the payload.
  // Between reads the bus inverts each cycle, so stale data never matches.
  always @(posedge clk) begin
    if (rd_en) begin
      rd_data <= {handle, 6'h00, dw_addr};
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule // rb_model
`default_nettype wire
